/* hdl/wdr_consts.svh */
`ifndef WDR_CONSTS_SVH
`define WDR_CONSTS_SVH

// ==========================================================
// Register map: word indices, byte address is index times four.
`define WDR_ADDR_W        12
`define WDR_IDX_W         10
`define WDR_IDX_CTRL      10'h0f0
`define WDR_IDX_CAUSE     10'h0ef

// ==========================================================
// Control register key codes and fields.
`define WDR_KEY_RESTART   8'ha5
`define WDR_KEY_DISARM1   8'hde
`define WDR_KEY_DISARM2   8'had
`define WDR_KEY_LOCK      8'hff
`define WDR_PROG_BIT      7
`define WDR_IVL_W         3
`define WDR_IVL_RESET     3'h7
`define WDR_WIN_W         3
`define WDR_WIN_CYCLES    3'h4
`define WDR_WIN_LAST      3'h1

// ==========================================================
// Counter geometry.
`define WDR_CNT_W         21
`define WDR_CNT_ONE       21'h000001
`define WDR_CNT_ZERO      21'h000000
`define WDR_IVL_BASE_LOG2 6
`define WDR_SHAMT_W       5

// ==========================================================
// Reset cause bit positions and power-on value.
`define WDR_CAUSE_W       7
`define WDR_BIT_FLASH     6
`define WDR_BIT_CMP       5
`define WDR_BIT_SW        4
`define WDR_BIT_WDOG      3
`define WDR_BIT_MCD       2
`define WDR_BIT_POR       1
`define WDR_BIT_PIN       0
`define WDR_CAUSE_POR     7'h02
`define WDR_CAUSE_NONE    7'h00

`endif

/* hdl/wdr_pkg.sv */
`default_nettype none
`include "wdr_consts.svh"

package wdr_pkg;

	// ==========================================================
	// Disable key sequence states.
	typedef enum logic [1:0] {
		WDR_SEQ_IDLE  = 2'b01,
		WDR_SEQ_ARMED = 2'b10
	} wdr_seq_t;

	typedef logic [`WDR_CAUSE_W-1:0] wdr_cause_t;

	// ==========================================================
	// Complete state of the watchdog top.
	typedef struct packed {
		logic [`WDR_CNT_W-1:0] cnt;
		logic                  run;
		logic                  locked;
		wdr_seq_t              seq;
		logic [`WDR_WIN_W-1:0] win;
		logic [`WDR_IVL_W-1:0] ivl;
		logic                  cmp_en;
		logic                  mcd_en;
		logic                  sup_en;
		logic                  rst_req;
		logic [31:0]           rdata;
	} wdr_main_state_t;

	// Complete state of the reset cause keeper.
	typedef struct packed {
		wdr_cause_t flags;
	} wdr_cause_state_t;

endpackage

`default_nettype wire

/* hdl/wdr_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser for levels that come from outside pclk.
module wdr_sync #(
	parameter int unsigned WIDTH   = 1,
	parameter logic        RST_VAL = 1'b0
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Asynchronous level in, synchronous level out.
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [1:0][WIDTH-1:0] stage_q;
	logic [1:0][WIDTH-1:0] stage_d;

	// The first stage feeds the second stage and nothing else.
	always_comb begin
		stage_d[0] = async_in;
		stage_d[1] = stage_q[0];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_q <= {(2*WIDTH){RST_VAL}};
		end else begin
			stage_q <= stage_d;
		end
	end

	assign sync_out = stage_q[1];

endmodule

`default_nettype wire

/* hdl/wdr_cause_keeper.sv */
`timescale 1ns/1ns
`default_nettype none

// Holds the cause of the latest reset; cleared only by power-on.
module wdr_cause_keeper
	import wdr_pkg::*;
(
	// Clock and power-on reset.
	input  wire logic       clk,
	input  wire logic       por_rstn,
	// Reset events, one bit per cause, same clock.
	input  wire wdr_cause_t events,
	// Recorded cause.
	output wdr_cause_t      flags
);

	wdr_cause_state_t s_q;
	wdr_cause_state_t s_d;

	// A new event replaces the old record so only the latest cause shows.
	always_comb begin
		s_d = s_q;
		if (|events) begin
			s_d.flags = events;
		end
	end

	// Power-on marks the supply flag; the others are then cleared.
	always_ff @(posedge clk or negedge por_rstn) begin
		if (!por_rstn) begin
			s_q.flags <= `WDR_CAUSE_POR;
		end else begin
			s_q <= s_d;
		end
	end

	assign flags = s_q.flags;

endmodule

`default_nettype wire

/* hdl/wdr_watchdog_top.sv */
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Counter overflow resets the whole chip.
// - Reset leaves watchdog running, longest interval.
// - Twenty-one bit counter on system clock.
// - Restart key enables and restarts count.
// - Disable needs second key within four cycles.
// - Lock key blocks disabling until reset.
// - Interval is four to three-plus-field cycles.
// - Control read returns interval, reset seven.
// - Watchdog reset never drives the reset pin.
// - Flash fault flag is read-only cause bit.
// - Comparator enable write, comparator cause read.
// - Software force write, software cause read.
// - Watchdog flag is read-only cause bit.
// - Missing clock enable write, its cause read.
// - Supply flag after power-on, enables monitor.
// - External pin flag is read-only cause bit.
// - Cause register at index ef, always visible.
module wdr_watchdog_top
	import wdr_pkg::*;
#(
	parameter int unsigned IVL_BASE_LOG2 = `WDR_IVL_BASE_LOG2
) (
	// Clock and resets.
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   por_rstn,
	// APB slave.
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`WDR_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Reset sources from the rest of the chip.
	input  wire logic                   reset_pin_n,
	input  wire logic                   comparator_out_n,
	input  wire logic                   clock_missing,
	input  wire logic                   supply_low,
	input  wire logic                   flash_fault,
	// Reset request and status.
	output logic                        sys_reset_req,
	output logic                        watchdog_running
);

	// ==========================================================
	// Parameter check.
	// The largest interval must still fit in the counter.
	if (IVL_BASE_LOG2 + 14 >= `WDR_CNT_W) begin : g_bad_base
		$error("IVL_BASE_LOG2 too large for the counter width");
	end

	// ==========================================================
	// Declarations.
	wdr_main_state_t            s_q;
	wdr_main_state_t            s_d;
	wdr_cause_t                 cause_flags;
	wdr_cause_t                 events;
	logic                       pin_n_sync;
	logic                       cmp_n_sync;
	logic                       mcd_sync;
	logic                       sup_sync;
	logic [`WDR_IDX_W-1:0]      word_idx;
	logic                       hit_ctrl;
	logic                       hit_cause;
	logic                       access;
	logic                       wr_ctrl;
	logic                       wr_cause;
	logic [7:0]                 wbyte;
	logic [`WDR_SHAMT_W-1:0]    shamt;
	logic [`WDR_CNT_W-1:0]      limit_m1;
	logic                       wdog_ovf;
	logic                       sw_force;

	// ==========================================================
	// Input synchronisers.
	// The pin synchroniser sits on the power-on reset so that it keeps
	// seeing the pin while the pin itself holds the system in reset.
	wdr_sync #(
		.WIDTH   (1),
		.RST_VAL (1'b1)
	) u_pin_sync (
		.clk      (pclk),
		.rst_n    (por_rstn),
		.async_in (reset_pin_n),
		.sync_out (pin_n_sync)
	);

	// The comparator output idles high, so its synchroniser resets high.
	wdr_sync #(
		.WIDTH   (1),
		.RST_VAL (1'b1)
	) u_cmp_sync (
		.clk      (pclk),
		.rst_n    (presetn),
		.async_in (comparator_out_n),
		.sync_out (cmp_n_sync)
	);

	// Missing clock and supply monitor alarms idle low.
	wdr_sync #(
		.WIDTH   (2),
		.RST_VAL (1'b0)
	) u_alarm_sync (
		.clk      (pclk),
		.rst_n    (presetn),
		.async_in ({clock_missing, supply_low}),
		.sync_out ({mcd_sync, sup_sync})
	);

	// ==========================================================
	// APB decode.
	// There is no register paging here, so the cause register answers at
	// the same address whatever else the system selects.
	assign word_idx  = paddr[`WDR_ADDR_W-1:2];
	assign hit_ctrl  = (word_idx == `WDR_IDX_CTRL);
	assign hit_cause = (word_idx == `WDR_IDX_CAUSE);
	assign access    = psel & penable;
	assign wbyte     = pwdata[7:0];

	// A write counts only with the low byte lane strobed; the registers
	// are eight bits wide and live in that lane.
	assign wr_ctrl  = access & pwrite & pstrb[0] & hit_ctrl;
	assign wr_cause = access & pwrite & pstrb[0] & hit_cause;

	// Zero wait states: read data is captured in the setup cycle.
	assign pready  = 1'b1;
	assign pslverr = access & ~(hit_ctrl | hit_cause);
	assign prdata  = s_q.rdata;

	// ==========================================================
	// Interval limit.
	// The interval is 4^(3+field) cycles, that is 2^(6+2*field). The
	// base exponent is a parameter so a simulation can shorten it.
	assign shamt    = `WDR_SHAMT_W'(IVL_BASE_LOG2) + {1'b0, s_q.ivl, 1'b0};
	assign limit_m1 = (`WDR_CNT_ONE << shamt) - `WDR_CNT_ONE;

	// ==========================================================
	// Reset cause record.
	// The event vector is formed at the end of the next-state process.
	// The cause record lives outside the system reset so it survives it.
	wdr_cause_keeper u_cause (
		.clk      (pclk),
		.por_rstn (por_rstn),
		.events   (events),
		.flags    (cause_flags)
	);

	// ==========================================================
	// Next state.
	always_comb begin
		s_d      = s_q;
		wdog_ovf = 1'b0;
		sw_force = 1'b0;

		// Counter advances every cycle while running.
		if (s_q.run) begin
			if (s_q.cnt >= limit_m1) begin
				wdog_ovf = 1'b1;
				s_d.cnt  = `WDR_CNT_ZERO;
			end else begin
				s_d.cnt = s_q.cnt + `WDR_CNT_ONE;
			end
		end

		// The disable window closes after its last cycle.
		if (s_q.seq == WDR_SEQ_ARMED) begin
			if (s_q.win == `WDR_WIN_LAST) begin
				s_d.seq = WDR_SEQ_IDLE;
				s_d.win = '0;
			end else begin
				s_d.win = s_q.win - `WDR_WIN_LAST;
			end
		end

		// Control register writes; any write ends a pending sequence
		// unless it is the first disable key itself.
		if (wr_ctrl) begin
			s_d.seq = WDR_SEQ_IDLE;
			s_d.win = '0;
			case (wbyte)
				`WDR_KEY_RESTART: begin
					s_d.run  = 1'b1;
					s_d.cnt  = `WDR_CNT_ZERO;
					wdog_ovf = 1'b0;
				end
				`WDR_KEY_DISARM1: begin
					s_d.seq = WDR_SEQ_ARMED;
					s_d.win = `WDR_WIN_CYCLES;
				end
				`WDR_KEY_DISARM2: begin
					// A late, unarmed or locked attempt is dropped silently.
					if (s_q.seq == WDR_SEQ_ARMED && !s_q.locked) begin
						s_d.run  = 1'b0;
						s_d.cnt  = `WDR_CNT_ZERO;
						wdog_ovf = 1'b0;
					end
				end
				`WDR_KEY_LOCK: begin
					s_d.locked = 1'b1;
				end
				default: begin
					// Only bytes with the top bit low program the interval.
					if (!wbyte[`WDR_PROG_BIT]) begin
						s_d.ivl = wbyte[`WDR_IVL_W-1:0];
					end
				end
			endcase
		end

		// Cause register writes: enables follow the written bits, and
		// the read-only flag positions take no write.
		if (wr_cause) begin
			s_d.cmp_en = wbyte[`WDR_BIT_CMP];
			s_d.mcd_en = wbyte[`WDR_BIT_MCD];
			s_d.sup_en = wbyte[`WDR_BIT_POR];
			sw_force   = wbyte[`WDR_BIT_SW];
		end

		// Reset events. The reset pin acts on the chip directly; it is only
		// recorded here and nothing in this block ever drives it. Forming the
		// vector here, after the overflow and force decisions, avoids a loop
		// between two combinational processes.
		events                 = `WDR_CAUSE_NONE;
		events[`WDR_BIT_FLASH] = flash_fault;
		events[`WDR_BIT_CMP]   = s_q.cmp_en & ~cmp_n_sync;
		events[`WDR_BIT_SW]    = sw_force;
		events[`WDR_BIT_WDOG]  = wdog_ovf;
		events[`WDR_BIT_MCD]   = s_q.mcd_en & mcd_sync;
		events[`WDR_BIT_POR]   = s_q.sup_en & sup_sync;
		events[`WDR_BIT_PIN]   = ~pin_n_sync;

		// Every cause except the pin asks for a system reset, one cycle
		// later and for as long as its event lasts; the reset controller stretches it as it needs.
		s_d.rst_req = |(events & ~(`WDR_CAUSE_NONE | (`WDR_CAUSE_W'(1) << `WDR_BIT_PIN)));

		// Read data is captured in the setup cycle of a read.
		if (psel && !penable && !pwrite) begin
			if (hit_ctrl) begin
				s_d.rdata = {29'h0000000, s_q.ivl};
			end else if (hit_cause) begin
				s_d.rdata = {25'h0000000, cause_flags};
			end else begin
				s_d.rdata = 32'h00000000;
			end
		end
	end

	// ==========================================================
	// State register.
	// After any system reset the watchdog runs with the longest interval.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.cnt     <= `WDR_CNT_ZERO;
			s_q.run     <= 1'b1;
			s_q.locked  <= 1'b0;
			s_q.seq     <= WDR_SEQ_IDLE;
			s_q.win     <= '0;
			s_q.ivl     <= `WDR_IVL_RESET;
			s_q.cmp_en  <= 1'b0;
			s_q.mcd_en  <= 1'b0;
			s_q.sup_en  <= 1'b0;
			s_q.rst_req <= 1'b0;
			s_q.rdata   <= 32'h00000000;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs.
	assign sys_reset_req    = s_q.rst_req;
	assign watchdog_running = s_q.run;

endmodule

`default_nettype wire

/* verification/wdr_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wdr_consts.svh"

// ==========
// Checker: ties status and reset request to the writes and sources behind them.
module wdr_checker (
	// Clock and reset.
	input wire logic                   pclk,
	input wire logic                   presetn,
	// APB slave.
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [`WDR_ADDR_W-1:0] paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [3:0]             pstrb,
	input wire logic [31:0]            prdata,
	input wire logic                   pslverr,
	// Sources and status.
	input wire logic                   flash_fault,
	input wire logic                   sys_reset_req,
	input wire logic                   watchdog_running
);
	logic acc;
	logic ctrl_wr;
	logic cause_wr;
	logic key_a5;
	logic key_ad;
	logic key_ff;

	// Decoded accesses; a write counts only with the low lane strobe.
	assign acc      = psel && penable;
	assign ctrl_wr  = acc && pwrite && pstrb[0] && (paddr[11:2] == `WDR_IDX_CTRL);
	assign cause_wr = acc && pwrite && pstrb[0] && (paddr[11:2] == `WDR_IDX_CAUSE);
	assign key_a5   = ctrl_wr && (pwdata[7:0] == `WDR_KEY_RESTART);
	assign key_ad   = ctrl_wr && (pwdata[7:0] == `WDR_KEY_DISARM2);
	assign key_ff   = ctrl_wr && (pwdata[7:0] == `WDR_KEY_LOCK);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Read setup of the control register followed by its access phase.
	sequence s_ctrl_read;
		psel && !penable && !pwrite && (paddr[11:2] == `WDR_IDX_CTRL) ##1 acc;
	endsequence

	unmapped_err_a: assert property (acc && (paddr[11:2] != `WDR_IDX_CTRL) && (paddr[11:2] != `WDR_IDX_CAUSE) |-> pslverr)
		else $error("unmapped access without error");
	cause_mapped_a: assert property (acc && (paddr[11:2] == `WDR_IDX_CAUSE) |-> !pslverr)
		else $error("cause register access flagged as error");
	ctrl_read_a: assert property (s_ctrl_read |-> (prdata[31:3] == 29'h0))
		else $error("control read shows more than the interval field");
	boot_run_a: assert property ($rose(presetn) |-> watchdog_running)
		else $error("watchdog not running after reset");
	restart_run_a: assert property (key_a5 |=> watchdog_running)
		else $error("restart key did not enable");
	lock_keep_a: assert property (key_ff |=> $stable(watchdog_running))
		else $error("lock key changed the running state");
	run_cause_a: assert property ($rose(watchdog_running) |-> $past(key_a5))
		else $error("watchdog started without restart key");
	stop_cause_a: assert property ($fell(watchdog_running) |-> $past(key_ad))
		else $error("watchdog stopped without second key");
	flash_req_a: assert property (flash_fault |=> sys_reset_req)
		else $error("flash fault did not request reset");
	sw_force_a: assert property (cause_wr && pwdata[4] |=> sys_reset_req)
		else $error("software force did not request reset");
endmodule

bind wdr_watchdog_top wdr_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
	.flash_fault(flash_fault), .sys_reset_req(sys_reset_req), .watchdog_running(watchdog_running));

`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========
// Bench: APB calls with expected values; base exponent 0 keeps intervals short.
module testbench;
	localparam int          BASE  = 0;
	localparam logic [11:0] CTRL  = 12'h3c0;
	localparam logic [11:0] CAUSE = 12'h3bc;
	logic        pclk = 1'b0, presetn = 1'b0, por_rstn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'hf;
	logic        pin_n = 1'b1, cmp_n = 1'b1, clk_miss = 1'b0, sup_low = 1'b0, flash = 1'b0;
	logic        pready, pslverr, sys_reset_req, watchdog_running, err, hit;
	int          bad_count = 0, compares = 0, k;

	wdr_watchdog_top #(.IVL_BASE_LOG2(BASE)) i_wdr_watchdog_top (.pclk(pclk), .presetn(presetn),
		.por_rstn(por_rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reset_pin_n(pin_n), .comparator_out_n(cmp_n), .clock_missing(clk_miss), .supply_low(sup_low),
		.flash_fault(flash), .sys_reset_req(sys_reset_req), .watchdog_running(watchdog_running));

	// Free-running 10 MHz clock.
	always #50 pclk = ~pclk;

	// ==========
	// Compare tasks, one per kind of result.
	task chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: %s read %h expected %h", $time, what, got, exp);
		end
	endtask

	task chk_flag(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: %s is %b expected %b", $time, what, got, exp);
		end
	endtask

	// ==========
	// Bus and stimulus tasks.
	task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task rdchk(input logic [11:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk_reg(rd, {24'h0, exp}, "register");
	endtask

	// Control write, then the running flag once the write has landed.
	task wkey(input logic [7:0] d, input logic exp);
		apb(1'b1, CTRL, d);
		@(negedge pclk);
		chk_flag(watchdog_running, exp, "running");
	endtask

	// System reset only; the cause record must survive it.
	task sysrst;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// Restart, then count edges until the overflow request shows.
	task ovf(input logic [2:0] ivl);
		apb(1'b1, CTRL, {5'h0, ivl});
		rdchk(CTRL, {5'h0, ivl});
		apb(1'b1, CTRL, 8'ha5);
		k = 0;
		@(negedge pclk);
		while (sys_reset_req !== 1'b1 && k < 100) begin
			@(negedge pclk);
			k++;
		end
		chk_reg(k, 32'h1 << (BASE + 2 * ivl), "overflow edges");
	endtask

	task drive(input int b, input logic v);
		@(posedge pclk);
		case (b)
			6: flash <= v;
			5: cmp_n <= !v;
			2: clk_miss <= v;
			1: sup_low <= v;
			0: pin_n <= !v;
			default: ;
		endcase
	endtask

	// Raise one source, write the cause register, watch for a request, read the record.
	task cause_ev(input int b, input logic [7:0] en, input logic req, input logic [7:0] cause);
		drive(b, 1'b1);
		apb(1'b1, CAUSE, en);
		hit = 1'b0;
		repeat (20) begin
			@(negedge pclk);
			if (sys_reset_req === 1'b1) hit = 1'b1;
		end
		chk_flag(hit, req, "reset request");
		drive(b, 1'b0);
		repeat (4) @(posedge pclk);
		rdchk(CAUSE, cause);
	endtask

	task results;
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake; the tests need well under 5000 cycles.
	initial begin
		#(20000 * 100);
		bad_count++;
		$display("Error at %0t: run did not finish", $time);
		results;
	end

	// ==========
	// Main sequence.
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		por_rstn <= 1'b1;
		@(negedge pclk);
		chk_flag(watchdog_running, 1'b1, "running after reset");
		rdchk(CTRL, 8'h07);
		rdchk(CAUSE, 8'h02);
		apb(1'b0, 12'h100, 8'h00);
		chk_flag(err, 1'b1, "unmapped error");
		$display("test reset values done");
		for (int i = 0; i < 3; i++) ovf(i[2:0]);
		sysrst;
		rdchk(CTRL, 8'h07);
		rdchk(CAUSE, 8'h08);
		$display("test intervals done");
		wkey(8'hde, 1'b1);
		wkey(8'had, 1'b0);
		wkey(8'ha5, 1'b1);
		wkey(8'hde, 1'b1);
		repeat (2) @(posedge pclk);
		wkey(8'had, 1'b1);
		wkey(8'hde, 1'b1);
		wkey(8'h03, 1'b1);
		wkey(8'had, 1'b1);
		wkey(8'hff, 1'b1);
		wkey(8'hde, 1'b1);
		wkey(8'had, 1'b1);
		sysrst;
		wkey(8'hde, 1'b1);
		wkey(8'had, 1'b0);
		wkey(8'hff, 1'b0);
		$display("test keys done");
		cause_ev(6, 8'h00, 1'b1, 8'h40);
		cause_ev(5, 8'h00, 1'b0, 8'h40);
		cause_ev(5, 8'h20, 1'b1, 8'h20);
		cause_ev(4, 8'h10, 1'b1, 8'h10);
		cause_ev(2, 8'h04, 1'b1, 8'h04);
		cause_ev(1, 8'h02, 1'b1, 8'h02);
		cause_ev(0, 8'h49, 1'b0, 8'h01);
		$display("test reset causes done");
		results;
	end
endmodule

`default_nettype wire
